// >>> hdl/sgz_access_check.sv
// Enable and trap decision for one write to the group 0 request register.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module sgz_access_check
    import sgz_pkg::*;
(
    input  wire sgz_pkg::sgz_level_t  level,
    input  wire logic                 secure_eff,
    input  wire logic                 monitor_mode,
    input  wire logic                 sysreg_enable_level1,
    input  wire logic                 sysreg_enable_level2,
    input  wire logic                 sysreg_enable_level3,
    input  wire logic                 el2_present,
    input  wire logic                 el2_is_64,
    input  wire logic                 el3_present,
    input  wire logic                 el3_is_64,
    input  wire logic                 hyp_fast_int_route,
    input  wire logic                 hyp_normal_int_route,
    input  wire logic                 hyp_coproc12_trap,
    input  wire logic                 hyp_common_reg_trap,
    input  wire logic                 monitor_fast_int_route,
    input  wire logic                 monitor_normal_int_route,
    output sgz_pkg::sgz_result_t      result
);
    // ======================================================================
    // Condition terms
    wire ns_el1    = (level == SGZ_EL1) && !secure_eff;
    wire mon_both  = monitor_fast_int_route && monitor_normal_int_route;
    wire hyp_any   = hyp_fast_int_route || hyp_normal_int_route;
    wire sre_off   = (level == SGZ_EL1 && !sysreg_enable_level1)
                  || (level == SGZ_EL2 && !sysreg_enable_level2)
                  || (level == SGZ_EL3 && !sysreg_enable_level3);
    wire a32_undef = el3_present && !el3_is_64 && mon_both
                  && (level == SGZ_EL2 || (level == SGZ_EL3 && !monitor_mode));
    wire h64_trap  = ns_el1 && el2_present && el2_is_64
                  && (hyp_any || hyp_coproc12_trap);
    wire h32_trap  = ns_el1 && el2_present && !el2_is_64 && hyp_any;
    wire h32_hyp   = ns_el1 && el2_present && !el2_is_64 && hyp_coproc12_trap;
    wire tc_trap   = ns_el1 && hyp_common_reg_trap;
    wire m64       = el3_present && el3_is_64 && mon_both;
    wire m64_trap  = m64 && ((level == SGZ_EL1 && secure_eff)
                  || level == SGZ_EL2
                  || (ns_el1 && !hyp_any));

    // Undefined first, then level 2 traps, then hyp traps, then level 3 traps
    always_comb
    begin
        if (level == SGZ_EL0 || sre_off || a32_undef)
            result = SGZ_ACC_UNDEF;
        else if (h64_trap || h32_trap || tc_trap)
            result = SGZ_ACC_TRAP_EL2;
        else if (h32_hyp)
            result = SGZ_ACC_TRAP_HYP;
        else if (m64_trap)
            result = SGZ_ACC_TRAP_EL3;
        else
            result = SGZ_ACC_OK;
    end

endmodule // sgz_access_check

// >>> hdl/sgz_pkg.sv
// Types shared by the issue logic and its access checker.
// Assumes the includer has no other package of the same name.
package sgz_pkg;

    // Exception level of the writer
    typedef enum logic [1:0] {SGZ_EL0, SGZ_EL1, SGZ_EL2, SGZ_EL3} sgz_level_t;

    // Outcome of the access checks for one write
    typedef enum logic [2:0] {
        SGZ_ACC_OK,
        SGZ_ACC_UNDEF,
        SGZ_ACC_TRAP_EL2,
        SGZ_ACC_TRAP_HYP,
        SGZ_ACC_TRAP_EL3
    } sgz_result_t;

endpackage

// >>> hdl/sgz_regs.svh
// Encodings, field positions and reset values of the group 0 request register.
// Included by the issue logic; definitions only.
`ifndef SGZ_REGS_SVH
`define SGZ_REGS_SVH

// ==========================================================================
// Write instruction encoding
`define SGZ_COPROC          4'hF
`define SGZ_OPC1            4'h2
`define SGZ_CRM             4'hC

// ==========================================================================
// Field positions of the written value
`define SGZ_AFFINITY_LEVEL_THREE_HI         55
`define SGZ_AFFINITY_LEVEL_THREE_LO         48
`define SGZ_ROUTE_BIT       40
`define SGZ_AFFINITY_LEVEL_TWO_HI         39
`define SGZ_AFFINITY_LEVEL_TWO_LO         32
`define SGZ_INTNUM_HI       27
`define SGZ_INTNUM_LO       24
`define SGZ_AFFINITY_LEVEL_ONE_HI         23
`define SGZ_AFFINITY_LEVEL_ONE_LO         16
`define SGZ_BITMAP_HI       15
`define SGZ_BITMAP_LO       0

// ==========================================================================
// Reset values
`define SGZ_RST_BITMAP      16'h0000
`define SGZ_RST_AFF         8'h00
`define SGZ_RST_INTNUM      4'h0

`endif

// >>> hdl/sgz_sgi0_issue.sv
// Group 0 software-generated interrupt issue logic of a CPU interface.
// Assumes the core and the distributor port run on core_clk.
//
// Contract
// - 64-bit write-only register, reached by coprocessor 15 write, opc1 2, CRm 12.
// - Bits 55:48 give level-3 affinity; zero when routing mode bit set.
// - Bits 39:32 give level-2 affinity; zero when routing mode bit set.
// - Bits 23:16 give level-1 affinity; zero when routing mode bit set.
// - Bit 40 chooses targeted routing or all elements except the writer.
// - Bits 27:24 give the interrupt number to raise.
// - Bits 15:0 are the target bitmap; zero when routing mode bit set.
// - Bitmap bits naming no valid target are ignored; error report optional.
// - Only elements with level-0 affinity below 16 are reachable by bitmap.
// - Distributor always accepts and acknowledges requests; may discard them.
// - Secure writes always generate; non-secure ones only where access control allows.
// - With security disable clear, non-secure writes skip targets not permitted.
// - Writes from monitor mode count as secure whatever the state bit says.
// - Write from a level whose system register enable is clear is undefined.
// - 64-bit hypervisor: non-secure level-1 write traps to level 2 on route/trap bits.
// - 32-bit hypervisor: route bits trap to level 2; coproc-12 bit to hyp.
// - Non-secure level-1 write traps to level 2 when common-register trap set.
// - 32-bit monitor, both routes set: level-2 and non-monitor level-3 writes undefined.
// - 64-bit monitor, both routes set: secure level-1 writes trap to level 3.
// - 64-bit monitor, both routes set: level-2 writes trap to level 3.
// - 64-bit monitor, both routes, hyp routes clear: non-secure level-1 traps to 3.
//
// Refused writes pulse one outcome; ready stays high.
// An accepted write holds its request until taken.
// One request is outstanding at a time.
`timescale 1ns/1ps
`include "sgz_regs.svh"

module sgz_sgi0_issue
    import sgz_pkg::*;
#(
    parameter logic SERR_ENABLE = 1'b1
)
(
    input  wire logic                 core_clk,
    input  wire logic                 resetn,

    // Core write port
    input  wire logic                 wr_valid,
    input  wire logic [3:0]           wr_coproc,
    input  wire logic [3:0]           wr_opc1,
    input  wire logic [3:0]           wr_crm,
    input  wire logic [63:0]          wr_data,
    input  wire sgz_pkg::sgz_level_t  wr_level,
    input  wire logic                 nonsecure_state_bit,
    input  wire logic                 monitor_mode,
    output logic                      wr_ready,
    output logic                      wr_done,
    output logic                      wr_undef,
    output logic                      wr_trap_el2,
    output logic                      wr_trap_hyp,
    output logic                      wr_trap_el3,

    // Enables and trap controls
    input  wire logic                 sysreg_enable_level1,
    input  wire logic                 sysreg_enable_level2,
    input  wire logic                 sysreg_enable_level3,
    input  wire logic                 el2_present,
    input  wire logic                 el2_is_64,
    input  wire logic                 el3_present,
    input  wire logic                 el3_is_64,
    input  wire logic                 hyp_fast_int_route,
    input  wire logic                 hyp_normal_int_route,
    input  wire logic                 hyp_coproc12_trap,
    input  wire logic                 hyp_common_reg_trap,
    input  wire logic                 monitor_fast_int_route,
    input  wire logic                 monitor_normal_int_route,
    input  wire logic                 security_disable_bit,

    // Per-target permission and presence, bit n is level-0 affinity n
    input  wire logic [15:0]          nonsecure_access_control,
    input  wire logic [15:0]          target_present,

    // Generate request to the distributor
    output logic                      gen_valid,
    input  wire logic                 gen_ack,
    output logic [3:0]                gen_interrupt_number,
    output logic                      gen_routing_mode_bit,
    output logic [7:0]                gen_affinity_level_three,
    output logic [7:0]                gen_affinity_level_two,
    output logic [7:0]                gen_affinity_level_one,
    output logic [15:0]               gen_target_element_bitmap,
    output logic                      gen_nonsecure,
    output logic                      gen_system_error
);

    // ======================================================================
    // Declarations
    typedef enum logic [0:0] {SGZ_IDLE, SGZ_PEND} sgz_state_t;

    sgz_state_t   state_q;
    sgz_state_t   state_d;
    sgz_result_t  check_res;

    // Write port: ready and outcomes
    logic         ready_q;
    logic         done_q;
    logic         undef_q;
    logic         trap2_q;
    logic         traph_q;
    logic         trap3_q;

    // Request held for the distributor
    logic         gvalid_q;
    logic         route_q;
    logic         ns_q;
    logic         serr_q;
    logic [3:0]   intnum_q;
    logic [7:0]   affinity_level_three_q;
    logic [7:0]   affinity_level_two_q;
    logic [7:0]   affinity_level_one_q;
    logic [15:0]  bitmap_q;

    // ======================================================================
    // Write decode
    // Register select on the instruction encoding
    wire hit       = wr_valid && ready_q
                  && wr_coproc == `SGZ_COPROC
                  && wr_opc1 == `SGZ_OPC1
                  && wr_crm == `SGZ_CRM;

    // Monitor mode forces secure
    wire secure_eff = !nonsecure_state_bit || monitor_mode;

    // Routing mode bit
    wire route_bit  = wr_data[`SGZ_ROUTE_BIT];

    // Affinity fields forced to zero in all-but-self mode
    wire [7:0] affinity_level_three_w = route_bit ? `SGZ_RST_AFF
                      : wr_data[`SGZ_AFFINITY_LEVEL_THREE_HI:`SGZ_AFFINITY_LEVEL_THREE_LO];
    wire [7:0] affinity_level_two_w = route_bit ? `SGZ_RST_AFF
                      : wr_data[`SGZ_AFFINITY_LEVEL_TWO_HI:`SGZ_AFFINITY_LEVEL_TWO_LO];
    wire [7:0] affinity_level_one_w = route_bit ? `SGZ_RST_AFF
                      : wr_data[`SGZ_AFFINITY_LEVEL_ONE_HI:`SGZ_AFFINITY_LEVEL_ONE_LO];
    wire [3:0] intnum_w = wr_data[`SGZ_INTNUM_HI:`SGZ_INTNUM_LO];

    // Raw bitmap, 16 bits only, so level-0 affinity 16 and up cannot be named
    wire [15:0] raw_map = route_bit ? `SGZ_RST_BITMAP
                        : wr_data[`SGZ_BITMAP_HI:`SGZ_BITMAP_LO];

    // Non-secure writes keep only permitted targets unless security disabled
    wire ns_filter  = !secure_eff && !security_disable_bit;
    wire [15:0] perm_map = ns_filter ? (raw_map & nonsecure_access_control)
                         : raw_map;

    // Drop bits naming absent elements, optionally flag it
    wire [15:0] final_map = perm_map & target_present;
    wire bad_bits   = SERR_ENABLE && |(raw_map & ~target_present);

    // Accepted only if every check passes
    wire accept_ok  = hit && check_res == SGZ_ACC_OK;

    // ======================================================================
    // Access checks
    // Enable and trap decision
    sgz_access_check u_check (
        .level                    (wr_level),
        .secure_eff               (secure_eff),
        .monitor_mode             (monitor_mode),
        .sysreg_enable_level1     (sysreg_enable_level1),
        .sysreg_enable_level2     (sysreg_enable_level2),
        .sysreg_enable_level3     (sysreg_enable_level3),
        .el2_present              (el2_present),
        .el2_is_64                (el2_is_64),
        .el3_present              (el3_present),
        .el3_is_64                (el3_is_64),
        .hyp_fast_int_route       (hyp_fast_int_route),
        .hyp_normal_int_route     (hyp_normal_int_route),
        .hyp_coproc12_trap        (hyp_coproc12_trap),
        .hyp_common_reg_trap      (hyp_common_reg_trap),
        .monitor_fast_int_route   (monitor_fast_int_route),
        .monitor_normal_int_route (monitor_normal_int_route),
        .result                   (check_res)
    );

    // ======================================================================
    // Request state machine
    // Idle takes a write; pending holds the request until acknowledged
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SGZ_IDLE:
            begin
                // Wait for a write that passes
                if (accept_ok)
                    state_d = SGZ_PEND;
            end
            SGZ_PEND:
            begin
                // Hold until taken
                if (gen_ack)
                    state_d = SGZ_IDLE;
            end
            default: state_d = SGZ_IDLE;
        endcase
    end

    // State and write-port handshake
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_q <= SGZ_IDLE;
            ready_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            // Ready falls as a write is accepted
            ready_q <= (state_d == SGZ_IDLE) && !accept_ok;
        end
    end

    // Outcome and request registers
    // One-cycle outcome pulses for each taken write
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            done_q  <= 1'b0;
            undef_q <= 1'b0;
            trap2_q <= 1'b0;
            traph_q <= 1'b0;
            trap3_q <= 1'b0;
        end
        else
        begin
            // At most one set per write
            done_q  <= accept_ok;
            undef_q <= hit && check_res == SGZ_ACC_UNDEF;
            trap2_q <= hit && check_res == SGZ_ACC_TRAP_EL2;
            traph_q <= hit && check_res == SGZ_ACC_TRAP_HYP;
            trap3_q <= hit && check_res == SGZ_ACC_TRAP_EL3;
        end
    end

    // Request fields, loaded on an accepted write
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            gvalid_q <= 1'b0;
            route_q  <= 1'b0;
            ns_q     <= 1'b0;
            serr_q   <= 1'b0;
            intnum_q <= `SGZ_RST_INTNUM;
            affinity_level_three_q   <= `SGZ_RST_AFF;
            affinity_level_two_q   <= `SGZ_RST_AFF;
            affinity_level_one_q   <= `SGZ_RST_AFF;
            bitmap_q <= `SGZ_RST_BITMAP;
        end
        else if (accept_ok)
        begin
            gvalid_q <= 1'b1;
            route_q  <= route_bit;
            ns_q     <= !secure_eff;
            serr_q   <= bad_bits;
            intnum_q <= intnum_w;
            affinity_level_three_q   <= affinity_level_three_w;
            affinity_level_two_q   <= affinity_level_two_w;
            affinity_level_one_q   <= affinity_level_one_w;
            bitmap_q <= final_map;
        end
        else
        begin
            // Release once taken
            if (gvalid_q && gen_ack)
                gvalid_q <= 1'b0;
            // Error flag: first cycle only
            serr_q <= 1'b0;
        end
    end

    // ======================================================================
    // Outputs
    // Write port
    assign wr_ready                  = ready_q;
    assign wr_done                   = done_q;
    assign wr_undef                  = undef_q;
    assign wr_trap_el2               = trap2_q;
    assign wr_trap_hyp               = traph_q;
    assign wr_trap_el3               = trap3_q;

    // Generate request
    assign gen_valid                 = gvalid_q;
    assign gen_interrupt_number      = intnum_q;
    assign gen_routing_mode_bit      = route_q;
    assign gen_affinity_level_three  = affinity_level_three_q;
    assign gen_affinity_level_two    = affinity_level_two_q;
    assign gen_affinity_level_one    = affinity_level_one_q;
    assign gen_target_element_bitmap = bitmap_q;
    assign gen_nonsecure             = ns_q;
    assign gen_system_error          = serr_q;

endmodule // sgz_sgi0_issue

// >>> tb/sgz_dist_model.sv
// Distributor stand-in: accepts every generate request after a set delay.
// Assumes gen_valid is held until acknowledged, all on core_clk.
`timescale 1ns/1ps

module sgz_dist_model
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        gen_valid,
    input  wire logic [3:0]  ack_delay,
    output logic             gen_ack
);
    logic [3:0] wait_q;

    // ==========================================================
    // Accept every request, acknowledge ack_delay + 1 cycles after gen_valid rises
    always_ff @(posedge core_clk)
    begin
        if (!resetn || gen_ack)
        begin
            wait_q  <= 4'h0;
            gen_ack <= 1'b0;
        end
        else if (gen_valid)
        begin
            wait_q  <= wait_q + 4'h1;
            gen_ack <= (wait_q >= ack_delay);
        end
    end
endmodule // sgz_dist_model

// >>> tb/sgz_sgi0_issue_checker.sv
// Port-level checker for the group 0 issue logic.
// Assumes one clock, core_clk, and synchronous resetn.
`timescale 1ns/1ps

module sgz_sgi0_issue_checker
    import sgz_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                resetn,
    input wire logic                wr_valid,
    input wire logic [3:0]          wr_coproc,
    input wire logic [3:0]          wr_opc1,
    input wire logic [3:0]          wr_crm,
    input wire sgz_pkg::sgz_level_t wr_level,
    input wire logic                nonsecure_state_bit,
    input wire logic                monitor_mode,
    input wire logic                wr_ready,
    input wire logic                wr_done,
    input wire logic                wr_undef,
    input wire logic                wr_trap_el2,
    input wire logic                wr_trap_hyp,
    input wire logic                wr_trap_el3,
    input wire logic                sysreg_enable_level1,
    input wire logic                hyp_common_reg_trap,
    input wire logic                security_disable_bit,
    input wire logic [15:0]         nonsecure_access_control,
    input wire logic [15:0]         target_present,
    input wire logic                gen_valid,
    input wire logic                gen_ack,
    input wire logic [3:0]          gen_interrupt_number,
    input wire logic                gen_routing_mode_bit,
    input wire logic [7:0]          gen_affinity_level_three,
    input wire logic [7:0]          gen_affinity_level_two,
    input wire logic [7:0]          gen_affinity_level_one,
    input wire logic [15:0]         gen_target_element_bitmap,
    input wire logic                gen_nonsecure,
    input wire logic                gen_system_error
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Write taken with the register's encoding, and all outcomes
    wire       hit  = wr_valid && wr_ready && wr_coproc == 4'hF && wr_opc1 == 4'h2
                      && wr_crm == 4'hC;
    wire [4:0] outs = {wr_trap_el3, wr_trap_hyp, wr_trap_el2, wr_undef, wr_done};

    // ==========================================================
    // Assertions
    a_one_answer: assert property (hit |=> $onehot(outs))
        else $error("taken write gave not exactly one outcome");
    a_bad_enc_silent: assert property (wr_valid && wr_ready && !hit |=> outs == 5'h00)
        else $error("foreign encoding gave an outcome");
    a_route_zero: assert property (gen_valid && gen_routing_mode_bit |->
        {gen_affinity_level_three, gen_affinity_level_two, gen_affinity_level_one,
         gen_target_element_bitmap} == 40'h0)
        else $error("all-but-self request carries targets");
    a_undef_level1: assert property (hit && wr_level == SGZ_EL1 && !sysreg_enable_level1
        |=> wr_undef)
        else $error("disabled level-1 write not undefined");
    a_common_trap: assert property (hit && wr_level == SGZ_EL1 && nonsecure_state_bit
        && !monitor_mode && sysreg_enable_level1 && hyp_common_reg_trap |=> wr_trap_el2)
        else $error("common-register trap missed");
    a_absent_ignored: assert property (gen_valid |->
        (gen_target_element_bitmap & ~target_present) == 16'h0)
        else $error("bitmap names absent element");
    a_ns_filter: assert property (gen_valid && gen_nonsecure
        && !security_disable_bit |->
        (gen_target_element_bitmap & ~nonsecure_access_control) == 16'h0)
        else $error("non-secure request reaches forbidden element");
    a_fields_hold: assert property (gen_valid && !gen_ack |=> gen_valid
        && $stable(gen_interrupt_number) && $stable(gen_target_element_bitmap))
        else $error("request changed before acceptance");
    a_ack_release: assert property (gen_valid && gen_ack |=> !gen_valid && wr_ready)
        else $error("accepted request not released");
    a_serr_first: assert property (gen_system_error |-> wr_done && gen_valid)
        else $error("error flag outside first request cycle");

    // Main scenarios reached
    c_done: cover property (wr_done);
    c_trap3: cover property (wr_trap_el3);
    c_serr: cover property (gen_system_error);
endmodule // sgz_sgi0_issue_checker

bind sgz_sgi0_issue sgz_sgi0_issue_checker i_sgz_sgi0_issue_checker (.core_clk, .resetn,
    .wr_valid, .wr_coproc, .wr_opc1, .wr_crm, .wr_level, .nonsecure_state_bit, .monitor_mode,
    .wr_ready, .wr_done, .wr_undef, .wr_trap_el2, .wr_trap_hyp, .wr_trap_el3,
    .sysreg_enable_level1, .hyp_common_reg_trap, .security_disable_bit,
    .nonsecure_access_control, .target_present, .gen_valid, .gen_ack, .gen_interrupt_number,
    .gen_routing_mode_bit, .gen_affinity_level_three, .gen_affinity_level_two,
    .gen_affinity_level_one, .gen_target_element_bitmap, .gen_nonsecure, .gen_system_error);

// >>> tb/test_soft_interrupt_group0_issue.sv
// Self-checking bench for the group 0 issue logic and its access checks.
// Assumes the design, its package and the distributor model are compiled first.
`timescale 1ns/1ps

module test_soft_interrupt_group0_issue;
    import sgz_pkg::*;
    logic core_clk, resetn, wr_valid, nonsecure_state_bit, monitor_mode, wr_ready, wr_done;
    logic wr_undef, wr_trap_el2, wr_trap_hyp, wr_trap_el3, gen_valid, gen_ack;
    logic sysreg_enable_level1, sysreg_enable_level2, sysreg_enable_level3, el2_present;
    logic el2_is_64, el3_present, el3_is_64, hyp_fast_int_route, hyp_normal_int_route;
    logic hyp_coproc12_trap, hyp_common_reg_trap, monitor_fast_int_route, security_disable_bit;
    logic monitor_normal_int_route, gen_routing_mode_bit, gen_nonsecure, gen_system_error;
    logic [3:0]  wr_coproc, wr_opc1, wr_crm, gen_interrupt_number, ack_delay;
    logic [7:0]  gen_affinity_level_three, gen_affinity_level_two, gen_affinity_level_one;
    logic [15:0] nonsecure_access_control, target_present, gen_target_element_bitmap;
    logic [63:0] wr_data;
    sgz_level_t  wr_level;
    int          errors, cmp_count;

    sgz_sgi0_issue i_sgz_sgi0_issue (.*);
    sgz_dist_model i_sgz_dist_model (.core_clk, .resetn, .gen_valid, .ack_delay, .gen_ack);

    // Clock, 50 MHz
    always #10 core_clk = ~core_clk;

    // ==========================================================
    // Helpers
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Controls: enables, level widths, route and trap bits
    task automatic setc(input logic [12:0] v);
        {sysreg_enable_level1, sysreg_enable_level2, sysreg_enable_level3, el2_present,
         el2_is_64, el3_present, el3_is_64, hyp_fast_int_route, hyp_normal_int_route,
         hyp_coproc12_trap, hyp_common_reg_trap, monitor_fast_int_route,
         monitor_normal_int_route} <= v;
    endtask

    // One write; ex is {el3, hyp, el2, undef, done}
    task automatic go(input logic [63:0] d, input logic [3:0] op, input sgz_level_t lv,
                      input logic ns, input logic mn, input logic [4:0] ex);
        logic [15:0] bm;
        logic        rm;
        int          n;
        n = 0;
        @(posedge core_clk);
        while (wr_ready !== 1'b1)
        begin
            n++;
            if (n > 60)
            begin
                errors++;
                print_verdict();
            end
            @(posedge core_clk);
        end
        rm = d[40];
        bm = rm ? 16'h0000 : d[15:0] & target_present
             & ((ns && !mn && !security_disable_bit) ? nonsecure_access_control : 16'hFFFF);
        {wr_valid, wr_opc1, wr_data, nonsecure_state_bit, monitor_mode} <=
            {1'b1, op, d, ns, mn};
        wr_level <= lv;
        @(posedge core_clk);
        wr_valid <= 1'b0;
        #1;
        chk({59'h0, wr_trap_el3, wr_trap_hyp, wr_trap_el2, wr_undef, wr_done}, {59'h0, ex});
        if (ex == 5'h01)
            chk({16'h0, gen_valid, gen_interrupt_number, gen_routing_mode_bit,
                 gen_affinity_level_three, gen_affinity_level_two, gen_affinity_level_one,
                 gen_target_element_bitmap, gen_nonsecure, gen_system_error},
                {16'h0, 1'b1, d[27:24], rm, rm ? 24'h0 : {d[55:48], d[39:32], d[23:16]},
                 bm, ns && !mn, !rm && |(d[15:0] & ~target_present)});
        @(posedge core_clk);
    endtask

    // Plain register hit raising interrupt 1 at element 0
    task automatic go1(input sgz_level_t lv, input logic ns, input logic mn,
                       input logic [4:0] ex);
        go(64'h0000_0000_0100_0001, 4'h2, lv, ns, mn, ex);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        {core_clk, resetn, wr_valid, nonsecure_state_bit, monitor_mode} = 5'h00;
        {wr_coproc, wr_opc1, wr_crm, wr_data, ack_delay} = {12'hF2C, 64'h0, 4'h0};
        wr_level = SGZ_EL0;
        {security_disable_bit, nonsecure_access_control, target_present} = {1'b0, 32'h00FF_FFFF};
        {errors, cmp_count} = {32'h0, 32'h0};
        setc(13'h1FC0);
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        go(64'hFF12_FE34_F5A6_F0F1, 4'h2, SGZ_EL1, 1'b0, 1'b0, 5'h01);
        go(64'h0012_0134_07A6_FFFF, 4'h2, SGZ_EL3, 1'b0, 1'b0, 5'h01);
        go(64'h0000_0000_0300_0F0F, 4'h0, SGZ_EL1, 1'b0, 1'b0, 5'h00);
        target_present <= 16'h7FFF;
        go(64'h0000_0000_0900_8001, 4'h2, SGZ_EL1, 1'b0, 1'b0, 5'h01);
        target_present <= 16'hFFFF;
        go(64'h0000_0000_0300_0F0F, 4'h2, SGZ_EL1, 1'b1, 1'b0, 5'h01);
        go(64'h0000_0000_0300_0F0F, 4'h2, SGZ_EL3, 1'b1, 1'b1, 5'h01);
        security_disable_bit <= 1'b1;
        go(64'h0000_0000_0300_0F0F, 4'h2, SGZ_EL1, 1'b1, 1'b0, 5'h01);
        ack_delay <= 4'h5;
        go(64'h0003_0002_0E01_0005, 4'h2, SGZ_EL2, 1'b1, 1'b0, 5'h01);
        go(64'h0000_0000_0A00_0002, 4'h2, SGZ_EL1, 1'b0, 1'b0, 5'h01);
        ack_delay <= 4'h0;
        go1(SGZ_EL0, 1'b0, 1'b0, 5'h02);
        setc(13'h0FC0);
        go1(SGZ_EL1, 1'b0, 1'b0, 5'h02);
        setc(13'h17C0);
        go1(SGZ_EL2, 1'b1, 1'b0, 5'h02);
        setc(13'h1BC0);
        go1(SGZ_EL3, 1'b0, 1'b0, 5'h02);
        setc(13'h1FE0);
        go1(SGZ_EL1, 1'b1, 1'b0, 5'h04);
        setc(13'h1FD0);
        go1(SGZ_EL1, 1'b1, 1'b0, 5'h04);
        setc(13'h1FC8);
        go1(SGZ_EL1, 1'b1, 1'b0, 5'h04);
        setc(13'h1EC8);
        go1(SGZ_EL1, 1'b1, 1'b0, 5'h08);
        setc(13'h1EE0);
        go1(SGZ_EL1, 1'b1, 1'b0, 5'h04);
        setc(13'h1FC4);
        go1(SGZ_EL1, 1'b1, 1'b0, 5'h04);
        setc(13'h1F83);
        go1(SGZ_EL2, 1'b1, 1'b0, 5'h02);
        go1(SGZ_EL3, 1'b0, 1'b0, 5'h02);
        go1(SGZ_EL3, 1'b0, 1'b1, 5'h01);
        setc(13'h1FC3);
        go1(SGZ_EL1, 1'b0, 1'b0, 5'h10);
        go1(SGZ_EL2, 1'b1, 1'b0, 5'h10);
        go1(SGZ_EL1, 1'b1, 1'b0, 5'h10);
        setc(13'h1FE3);
        go1(SGZ_EL1, 1'b1, 1'b0, 5'h04);
        repeat (4) @(posedge core_clk);
        print_verdict();
    end
endmodule // test_soft_interrupt_group0_issue
